// file: hpm_pkg.sv
// ----------------------------------------
// shared constants of the page memory host
// ----------------------------------------
package hpm_pkg;
   // system clock and two-wire bit timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int SCL_PERIOD_NS = 10000;
   // a quarter of the serial clock period, in system cycles
   localparam int QUARTER_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
   localparam int QUARTER_W = 16;

   // byte framing
   localparam logic [3:0] ACK_SLOT = 4'h8;
   localparam logic [3:0] ROW_BYTES = 4'h8;
   localparam logic [7:0] IDLE_BYTE = 8'hFF;

   // direction bit in bit zero of the address byte
   localparam logic DIR_WRITE = 1'h0;
   localparam logic DIR_READ = 1'h1;

   // the device's slave addresses, 7-bit form
   localparam logic [6:0] AUX_ADDR = 7'h50;
   localparam logic [6:0] MAIN_ADDR_DEFAULT_1 = 7'h51;
   localparam logic [6:0] MAIN_ADDR_DEFAULT_2 = 7'h59;

   // acknowledge polling attempts before giving up
   localparam int POLL_LIMIT = 1000;
   localparam int POLL_W = 12;

   // bit-level operations of the pin engine
   typedef enum logic [1:0] {
      OP_START,
      OP_STOP,
      OP_BIT
   } hpm_op_t;
endpackage

// file: hpm_bit_if.sv
`timescale 1ns/10ps
// ----------------------------------------
// byte sequencer to pin engine
// ----------------------------------------
interface hpm_bit_if;
   logic req;
   hpm_pkg::hpm_op_t op;
   logic tx_bit;
   logic done;
   logic rx_bit;

   modport master (
      output req,
      output op,
      output tx_bit,
      input done,
      input rx_bit
   );
   modport engine (
      input req,
      input op,
      input tx_bit,
      output done,
      output rx_bit
   );
endinterface

// file: hpm_bit_engine.sv
`timescale 1ns/10ps
module hpm_bit_engine #(
   parameter int QUARTER_CYC = hpm_pkg::QUARTER_CYC
) (
   // system
   input wire logic clk,
   input wire logic rst,
   // serial clock pin, open drain
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_n,
   // serial data pin, open drain
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n,
   // requests from the sequencer
   hpm_bit_if.engine bus
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic scl_m_q, scl_s_q, sda_m_q, sda_s_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scl_m_q <= 1'h1;
         scl_s_q <= 1'h1;
         sda_m_q <= 1'h1;
         sda_s_q <= 1'h1;
      end else begin
         scl_m_q <= scl_i;
         scl_s_q <= scl_m_q;
         sda_m_q <= sda_i;
         sda_s_q <= sda_m_q;
      end
   end

   // ----------------------------------------
   // line levels per step, 1 = released
   // ----------------------------------------
   function automatic logic [1:0] lines(input hpm_pkg::hpm_op_t op, input logic [1:0] step, input logic b,
                                        input logic scl_now);
      logic [1:0] r;
      r = 2'h3;
      unique case (op)
         hpm_pkg::OP_START: r = (step == 2'h0) ? {scl_now, 1'h1} : (step == 2'h1) ? 2'h3 :
                                (step == 2'h2) ? 2'h2 : 2'h0;
         hpm_pkg::OP_STOP: r = (step == 2'h0) ? 2'h0 : (step == 2'h1) ? 2'h2 : 2'h3;
         // data set while clock low, held high
         hpm_pkg::OP_BIT: r = {(step == 2'h1 || step == 2'h2), b};
      endcase
      return r;
   endfunction

   // ----------------------------------------
   // step sequencer
   // ----------------------------------------
   logic busy_q, busy_d, bit_q, bit_d, done_q, done_d, rx_q, rx_d;
   logic scl_rel_q, scl_rel_d, sda_rel_q, sda_rel_d;
   logic [1:0] step_q, step_d;
   logic [hpm_pkg::QUARTER_W-1:0] cnt_q, cnt_d;
   hpm_pkg::hpm_op_t op_q, op_d;
   logic tick;

   assign tick = (cnt_q == hpm_pkg::QUARTER_W'(QUARTER_CYC - 1));

   always_comb begin
      busy_d = busy_q;
      bit_d = bit_q;
      op_d = op_q;
      step_d = step_q;
      cnt_d = cnt_q;
      rx_d = rx_q;
      done_d = 1'h0;
      {scl_rel_d, sda_rel_d} = {scl_rel_q, sda_rel_q};
      if (!busy_q) begin
         cnt_d = '0;
         if (bus.req) begin
            busy_d = 1'h1;
            op_d = bus.op;
            bit_d = bus.tx_bit;
            step_d = 2'h0;
         end
      end else begin
         {scl_rel_d, sda_rel_d} = lines(op_q, step_q, bit_q, scl_rel_q);
         // a released clock held low by the far end stalls the quarter count
         if (step_q == 2'h1 && !scl_s_q)
            cnt_d = '0;
         else if (tick)
            cnt_d = '0;
         else
            cnt_d = cnt_q + 1'h1;
         if (tick && !(step_q == 2'h1 && !scl_s_q)) begin
            // sample midway through clock high, at the end of step 1
            if (op_q == hpm_pkg::OP_BIT && step_q == 2'h1)
               rx_d = sda_s_q;
            step_d = step_q + 1'h1;
            if (step_q == 2'h3) begin
               busy_d = 1'h0;
               done_d = 1'h1;
            end
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         busy_q <= 1'h0;
         bit_q <= 1'h1;
         op_q <= hpm_pkg::OP_STOP;
         step_q <= 2'h0;
         cnt_q <= '0;
         rx_q <= 1'h1;
         done_q <= 1'h0;
         scl_rel_q <= 1'h1;
         sda_rel_q <= 1'h1;
         scl_o <= 1'h0;
         sda_o <= 1'h0;
      end else begin
         busy_q <= busy_d;
         bit_q <= bit_d;
         op_q <= op_d;
         step_q <= step_d;
         cnt_q <= cnt_d;
         rx_q <= rx_d;
         done_q <= done_d;
         scl_rel_q <= scl_rel_d;
         sda_rel_q <= sda_rel_d;
         scl_o <= 1'h0;
         sda_o <= 1'h0;
      end
   end

   assign scl_oe_n = scl_rel_q;
   assign sda_oe_n = sda_rel_q;
   assign bus.done = done_q;
   assign bus.rx_bit = rx_q;
endmodule

// file: hpm_host_top.sv
`timescale 1ns/10ps
// Behaviour
// - start: data falls while clock high
// - stop: data rises while clock high
// - repeated start issued like normal start
// - data changes only while clock low
// - ninth bit is acknowledge, low means ack
// - eight bits, msb first; device acks writes
// - host acks all but last read byte
// - direction zero writes, one reads
// - single write: start, addr, mem, data, stop
// - end each row with stop, then wait
// - dummy write, repeated start, then read
module hpm_host_top #(
   parameter int QUARTER_CYC = hpm_pkg::QUARTER_CYC,
   parameter int POLL_LIMIT = hpm_pkg::POLL_LIMIT
) (
   // system
   input wire logic clk,
   input wire logic rst,
   // command
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic cmd_read,
   input wire logic cmd_set_addr,
   input wire logic [6:0] cmd_dev,
   input wire logic [7:0] cmd_mem_addr,
   input wire logic [3:0] cmd_len,
   // write data
   input wire logic wr_valid,
   input wire logic [7:0] wr_data,
   output logic wr_ready,
   // read data
   output logic rd_valid,
   output logic [7:0] rd_data,
   // result
   output logic done,
   output logic err,
   output logic busy,
   // two-wire pins, open drain
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_n,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n
);
   // ----------------------------------------
   // types and helpers
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_START,
      ST_BYTE,
      ST_WAITWR,
      ST_STOP
   } hpm_state_t;

   typedef enum logic [2:0] {
      PH_DEV,
      PH_MEM,
      PH_RDEV,
      PH_WDATA,
      PH_RDATA
   } hpm_phase_t;

   // stop writes at row end, no wrap
   function automatic logic [3:0] row_clip(input logic [7:0] addr, input logic [3:0] len);
      logic [3:0] room;
      logic [3:0] want;
      room = hpm_pkg::ROW_BYTES - {1'h0, addr[2:0]};
      want = (len == 4'h0) ? 4'h1 : len;
      return (want > room) ? room : want;
   endfunction

   // ----------------------------------------
   // pin engine
   // ----------------------------------------
   hpm_bit_if bus ();

   hpm_bit_engine #(
      .QUARTER_CYC(QUARTER_CYC)
   ) u_engine (
      .clk(clk),
      .rst(rst),
      .scl_i(scl_i),
      .scl_o(scl_o),
      .scl_oe_n(scl_oe_n),
      .sda_i(sda_i),
      .sda_o(sda_o),
      .sda_oe_n(sda_oe_n),
      .bus(bus.engine)
   );

   // ----------------------------------------
   // transfer sequencer
   // ----------------------------------------
   hpm_state_t state_q, state_d;
   hpm_phase_t phase_q, phase_d;
   hpm_pkg::hpm_op_t op_q, op_d;
   logic req_q, req_d, txb_q, txb_d, wait_q, wait_d;
   logic read_q, read_d, setaddr_q, setaddr_d, again_q, again_d;
   logic [6:0] dev_q, dev_d;
   logic [7:0] mem_q, mem_d, sh_q, sh_d;
   logic [3:0] bitcnt_q, bitcnt_d, left_q, left_d;
   logic [hpm_pkg::POLL_W-1:0] tries_q, tries_d;
   logic cmd_ready_q, cmd_ready_d, wr_ready_q, wr_ready_d;
   logic rd_valid_q, rd_valid_d, done_q, done_d, err_q, err_d, busy_q, busy_d;
   logic [7:0] rd_data_q, rd_data_d;
   logic rx_mode, ack_n, bit_out;

   assign rx_mode = (phase_q == PH_RDATA);
   assign ack_n = bus.rx_bit;

   always_comb begin
      // msb first; ninth slot is acknowledge
      if (bitcnt_q == hpm_pkg::ACK_SLOT)
         // nack only the final read byte
         bit_out = rx_mode ? (left_q == 4'h1) : 1'h1;
      else
         // released so the device drives read bits
         bit_out = rx_mode ? 1'h1 : sh_q[7];
   end

   always_comb begin
      state_d = state_q;
      phase_d = phase_q;
      op_d = op_q;
      req_d = 1'h0;
      txb_d = txb_q;
      wait_d = wait_q;
      read_d = read_q;
      setaddr_d = setaddr_q;
      again_d = again_q;
      dev_d = dev_q;
      mem_d = mem_q;
      sh_d = sh_q;
      bitcnt_d = bitcnt_q;
      left_d = left_q;
      tries_d = tries_q;
      cmd_ready_d = cmd_ready_q;
      wr_ready_d = wr_ready_q;
      rd_valid_d = 1'h0;
      rd_data_d = rd_data_q;
      done_d = 1'h0;
      err_d = err_q;
      unique case (state_q)
         ST_IDLE: begin
            cmd_ready_d = 1'h1;
            if (cmd_valid && cmd_ready_q) begin
               cmd_ready_d = 1'h0;
               read_d = cmd_read;
               // writes always carry the memory address
               setaddr_d = cmd_set_addr || !cmd_read;
               dev_d = cmd_dev;
               mem_d = cmd_mem_addr;
               left_d = cmd_read ? ((cmd_len == 4'h0) ? 4'h1 : cmd_len) : row_clip(cmd_mem_addr, cmd_len);
               tries_d = '0;
               err_d = 1'h0;
               phase_d = PH_DEV;
               wait_d = 1'h0;
               state_d = ST_START;
            end
         end
         // repeated start uses the same sequence
         ST_START: begin
            if (!wait_q) begin
               req_d = 1'h1;
               op_d = hpm_pkg::OP_START;
               wait_d = 1'h1;
            end else if (bus.done) begin
               wait_d = 1'h0;
               bitcnt_d = 4'h0;
               // address in upper bits, direction in bit zero
               // plain read takes no memory address
               sh_d = {dev_q, (phase_q == PH_RDEV || !setaddr_q) ? hpm_pkg::DIR_READ : hpm_pkg::DIR_WRITE};
               state_d = ST_BYTE;
            end
         end
         ST_BYTE: begin
            if (!wait_q) begin
               req_d = 1'h1;
               op_d = hpm_pkg::OP_BIT;
               txb_d = bit_out;
               wait_d = 1'h1;
            end else if (bus.done) begin
               wait_d = 1'h0;
               if (bitcnt_q != hpm_pkg::ACK_SLOT) begin
                  sh_d = {sh_q[6:0], bus.rx_bit};
                  bitcnt_d = bitcnt_q + 4'h1;
               end else begin
                  bitcnt_d = 4'h0;
                  state_d = ST_STOP;
                  unique case (phase_q)
                     PH_DEV: begin
                        // high in the ack slot is refusal
                        if (ack_n) begin
                           if (tries_q == hpm_pkg::POLL_W'(POLL_LIMIT - 1)) begin
                              err_d = 1'h1;
                           end else begin
                              tries_d = tries_q + 1'h1;
                              again_d = 1'h1;
                           end
                        end else if (!setaddr_q) begin
                           phase_d = PH_RDATA;
                           sh_d = hpm_pkg::IDLE_BYTE;
                           state_d = ST_BYTE;
                        end else begin
                           // memory address follows the address byte
                           phase_d = PH_MEM;
                           sh_d = mem_q;
                           state_d = ST_BYTE;
                        end
                     end
                     PH_MEM: begin
                        if (ack_n) begin
                           err_d = 1'h1;
                        end else if (read_q) begin
                           phase_d = PH_RDEV;
                           state_d = ST_START;
                        end else begin
                           wr_ready_d = 1'h1;
                           state_d = ST_WAITWR;
                        end
                     end
                     PH_RDEV: begin
                        if (ack_n) begin
                           err_d = 1'h1;
                        end else begin
                           phase_d = PH_RDATA;
                           sh_d = hpm_pkg::IDLE_BYTE;
                           state_d = ST_BYTE;
                        end
                     end
                     PH_WDATA: begin
                        // each written byte must be acknowledged
                        if (ack_n) begin
                           err_d = 1'h1;
                        end else begin
                           left_d = left_q - 4'h1;
                           if (left_q != 4'h1) begin
                              wr_ready_d = 1'h1;
                              state_d = ST_WAITWR;
                           end
                        end
                     end
                     PH_RDATA: begin
                        rd_valid_d = 1'h1;
                        rd_data_d = sh_q;
                        left_d = left_q - 4'h1;
                        if (left_q != 4'h1) begin
                           sh_d = hpm_pkg::IDLE_BYTE;
                           state_d = ST_BYTE;
                        end
                     end
                     default: begin
                        err_d = 1'h1;
                     end
                  endcase
               end
            end
         end
         ST_WAITWR: begin
            if (wr_valid && wr_ready_q) begin
               wr_ready_d = 1'h0;
               sh_d = wr_data;
               bitcnt_d = 4'h0;
               phase_d = PH_WDATA;
               state_d = ST_BYTE;
            end
         end
         // each write ends with a stop
         ST_STOP: begin
            if (!wait_q) begin
               req_d = 1'h1;
               op_d = hpm_pkg::OP_STOP;
               wait_d = 1'h1;
            end else if (bus.done) begin
               wait_d = 1'h0;
               if (again_q) begin
                  again_d = 1'h0;
                  phase_d = PH_DEV;
                  state_d = ST_START;
               end else begin
                  done_d = 1'h1;
                  state_d = ST_IDLE;
               end
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
      busy_d = (state_d != ST_IDLE);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_IDLE;
         phase_q <= PH_DEV;
         op_q <= hpm_pkg::OP_STOP;
         req_q <= 1'h0;
         txb_q <= 1'h1;
         wait_q <= 1'h0;
         read_q <= 1'h0;
         setaddr_q <= 1'h0;
         again_q <= 1'h0;
         dev_q <= 7'h00;
         mem_q <= 8'h00;
         sh_q <= 8'hFF;
         bitcnt_q <= 4'h0;
         left_q <= 4'h0;
         tries_q <= '0;
         cmd_ready_q <= 1'h0;
         wr_ready_q <= 1'h0;
         rd_valid_q <= 1'h0;
         rd_data_q <= 8'h00;
         done_q <= 1'h0;
         err_q <= 1'h0;
         busy_q <= 1'h0;
      end else begin
         state_q <= state_d;
         phase_q <= phase_d;
         op_q <= op_d;
         req_q <= req_d;
         txb_q <= txb_d;
         wait_q <= wait_d;
         read_q <= read_d;
         setaddr_q <= setaddr_d;
         again_q <= again_d;
         dev_q <= dev_d;
         mem_q <= mem_d;
         sh_q <= sh_d;
         bitcnt_q <= bitcnt_d;
         left_q <= left_d;
         tries_q <= tries_d;
         cmd_ready_q <= cmd_ready_d;
         wr_ready_q <= wr_ready_d;
         rd_valid_q <= rd_valid_d;
         rd_data_q <= rd_data_d;
         done_q <= done_d;
         err_q <= err_d;
         busy_q <= busy_d;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign bus.req = req_q;
   assign bus.op = op_q;
   assign bus.tx_bit = txb_q;
   assign cmd_ready = cmd_ready_q;
   assign wr_ready = wr_ready_q;
   assign rd_valid = rd_valid_q;
   assign rd_data = rd_data_q;
   assign done = done_q;
   assign err = err_q;
   assign busy = busy_q;
endmodule

// file: hpm_host_sva.sv
`timescale 1ns/10ps
module hpm_host_sva #(
   parameter int QUARTER_CYC = hpm_pkg::QUARTER_CYC
) (
   // system
   input wire logic clk,
   input wire logic rst,
   // command
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire logic cmd_read,
   input wire logic [6:0] cmd_dev,
   // data and result
   input wire logic wr_ready,
   input wire logic rd_valid,
   input wire logic done,
   input wire logic busy,
   // pin enables
   input wire logic scl_oe_n,
   input wire logic sda_oe_n
);
   localparam int SPAN = 8 * QUARTER_CYC;
   logic scl_q, sda_q, first_q, first_d, rd_q, rd_d, rise, start;
   logic [3:0] bit_q, bit_d;
   logic [6:0] dev_q, dev_d;
   // ----------------------------------------
   // bit position inside the current byte
   // ----------------------------------------
   always_comb begin
      rise = scl_oe_n && !scl_q;
      start = sda_q && !sda_oe_n && scl_oe_n;
      bit_d = bit_q;
      first_d = first_q;
      dev_d = dev_q;
      rd_d = rd_q;
      if (cmd_valid && cmd_ready) begin
         dev_d = cmd_dev;
         rd_d = cmd_read;
      end
      if (start) begin
         bit_d = 4'h0;
         first_d = 1'b1;
      end else if (rise) begin
         bit_d = (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
         first_d = first_q && (bit_q != 4'h8);
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         bit_q <= 4'h0;
         first_q <= 1'b0;
         dev_q <= 7'h00;
         rd_q <= 1'b0;
      end else begin
         scl_q <= scl_oe_n;
         sda_q <= sda_oe_n;
         bit_q <= bit_d;
         first_q <= first_d;
         dev_q <= dev_d;
         rd_q <= rd_d;
      end
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_start_end;
      ##[1:SPAN] ($fell(scl_oe_n) && !sda_oe_n);
   endsequence
   sequence s_bus_free;
      (scl_oe_n && sda_oe_n) [*3];
   endsequence
   property p_start;
      start |-> s_start_end;
   endproperty
   property p_stop;
      scl_oe_n && scl_q && !sda_q && sda_oe_n |-> s_bus_free;
   endproperty
   property p_stable;
      rise |-> $stable(sda_oe_n) [*3];
   endproperty
   property p_addr;
      rise && first_q && bit_q < 4'h7 |-> sda_oe_n == dev_q[3'h6 - bit_q[2:0]];
   endproperty
   property p_dir;
      rise && first_q && bit_q == 4'h7 && !rd_q |-> !sda_oe_n;
   endproperty
   property p_ack_free;
      rise && bit_q == 4'h8 && (first_q || !rd_q) |-> sda_oe_n;
   endproperty
   property p_done_idle;
      done |-> sda_oe_n && scl_oe_n ##[1:2] cmd_ready;
   endproperty
   property p_rd_only;
      rd_valid |-> rd_q && busy;
   endproperty
   property p_wr_only;
      wr_ready |-> !rd_q && busy;
   endproperty
   a_start: assert property (p_start) else $error("start not closed by clock low");
   a_stop: assert property (p_stop) else $error("stop not followed by free bus");
   a_stable: assert property (p_stable) else $error("data moved while clock high");
   a_addr: assert property (p_addr) else $error("address bit wrong");
   a_dir: assert property (p_dir) else $error("write direction bit not zero");
   a_ack_free: assert property (p_ack_free) else $error("data held in acknowledge slot");
   a_done_idle: assert property (p_done_idle) else $error("done with bus not idle");
   a_rd_only: assert property (p_rd_only) else $error("read byte outside read");
   a_wr_only: assert property (p_wr_only) else $error("write byte requested in read");
endmodule

bind hpm_host_top hpm_host_sva #(.QUARTER_CYC(QUARTER_CYC)) u_sva (
   .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
   .cmd_read(cmd_read), .cmd_dev(cmd_dev), .wr_ready(wr_ready), .rd_valid(rd_valid),
   .done(done), .busy(busy), .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n)
);

// file: hpm_dev_model.sv
`timescale 1ns/10ps
module hpm_dev_model #(
   parameter int WR_NS = 8000
) (
   // two-wire pins
   input wire logic scl,
   input wire logic sda,
   output logic sda_oe_n,
   // configuration
   input wire logic shadow_write_mode
);
   logic [7:0] mem [256];
   logic [7:0] ptr, sh, tx;
   logic act, rd, nack, wrote, nv_busy;
   int cnt, ph;
   initial begin
      foreach (mem[i]) mem[i] = 8'h00;
      {sda_oe_n, act, wrote, nv_busy, ptr, cnt, ph} = {4'h8, 8'h00, 32'd0, 32'd4};
   end
   // ----------------------------------------
   // framing conditions
   // ----------------------------------------
   // start
   always @(negedge sda) if (scl === 1'b1) begin
      act = 1'b1;
      ph = 0;
      cnt = 0;
   end
   always @(posedge sda) if (scl === 1'b1 && act) begin
      act = 1'b0;
      if (wrote && !shadow_write_mode) begin
         nv_busy = 1'b1;
         nv_busy <= #(WR_NS) 1'b0;
      end
      wrote = 1'b0;
   end
   // ----------------------------------------
   // bits and bytes
   // ----------------------------------------
   // sample on rising clock, msb first
   always @(posedge scl) if (act) begin
      if (cnt < 8) sh = {sh[6:0], sda};
      else if (ph == 3) nack = sda;
      cnt++;
   end
   // drive only after the falling clock
   always @(negedge scl) if (act) begin
      sda_oe_n = 1'b1;
      if (cnt == 8 && ph == 0) begin
         rd = sh[0];
         if (!nv_busy && (sh[7:1] == 7'h50 || sh[7:1] == 7'h51 || sh[7:1] == 7'h59)) sda_oe_n = 1'b0;
         else ph = 4;
      end else if (cnt == 8 && ph == 1) begin
         ptr = sh;
         sda_oe_n = 1'b0;
      end else if (cnt == 8 && ph == 2) begin
         // only the written byte changes; counter wraps in row
         mem[ptr] = sh;
         ptr = {ptr[7:3], ptr[2:0] + 3'h1};
         wrote = 1'b1;
         sda_oe_n = 1'b0;
      end else if (cnt == 9) begin
         cnt = 0;
         if (ph == 0) ph = rd ? 3 : 1;
         else if (ph == 1) ph = 2;
         else if (ph == 3 && nack) ph = 4;
         if (ph == 3) begin
            tx = mem[ptr];
            ptr = ptr + 8'h01;
         end
      end
      if (ph == 3 && cnt < 8) sda_oe_n = tx[7 - cnt];
   end
endmodule

// file: tb_hpm_host_top.sv
`timescale 1ns/10ps
module tb_hpm_host_top;
   logic clk, rst, cmd_valid, cmd_ready, cmd_read, cmd_set_addr, wr_valid, wr_ready;
   logic rd_valid, done, err, busy, er, scl_o, scl_oe_n, sda_o, sda_oe_n, dev_sda_oe_n;
   logic [6:0] cmd_dev;
   logic [7:0] cmd_mem_addr, wr_data, rd_data;
   logic [3:0] cmd_len;
   logic [7:0] wq [8];
   logic [7:0] got [$];
   int miscompares, n_tests, cyc, nwr, nstart;
   // pull-ups on both lines
   wire scl = scl_oe_n ? 1'b1 : scl_o;
   wire sda = (sda_oe_n ? 1'b1 : sda_o) & dev_sda_oe_n;
   // one start per address attempt, so polling depth is visible
   always @(negedge sda) if (scl === 1'b1) nstart++;
   hpm_host_top #(.QUARTER_CYC(4), .POLL_LIMIT(4)) u_dut (
      .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
      .cmd_set_addr(cmd_set_addr), .cmd_dev(cmd_dev), .cmd_mem_addr(cmd_mem_addr), .cmd_len(cmd_len),
      .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready), .rd_valid(rd_valid),
      .rd_data(rd_data), .done(done), .err(err), .busy(busy), .scl_i(scl), .scl_o(scl_o),
      .scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n)
   );
   // write time spans about one and a half address attempts, so polling is exercised
   hpm_dev_model #(.WR_NS(8000)) u_dev (
      .scl(scl), .sda(sda), .sda_oe_n(dev_sda_oe_n), .shadow_write_mode(1'b0)
   );
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         miscompares++;
         report_and_stop();
      end
   end
   task automatic xfer(input logic rd, input logic sa, input logic [6:0] dev, input logic [7:0] ma,
                       input logic [3:0] n);
      @(negedge clk);
      {cmd_read, cmd_set_addr, cmd_dev, cmd_mem_addr, cmd_len} = {rd, sa, dev, ma, n};
      cmd_valid = 1'b1;
      wr_valid = !rd;
      wr_data = wq[0];
      nwr = 0;
      nstart = 0;
      got.delete();
      while (cmd_ready !== 1'b1) @(negedge clk);
      @(negedge clk);
      cmd_valid = 1'b0;
      while (done !== 1'b1) begin
         @(negedge clk);
         if (rd_valid === 1'b1) got.push_back(rd_data);
         wr_data = wq[nwr % 8];
         if (wr_ready === 1'b1 && wr_valid) nwr++;
      end
      wr_valid = 1'b0;
      er = err;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_write_read;
      wq = '{8'hA5, 8'h3C, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      xfer(1'b0, 1'b0, 7'h50, 8'h10, 4'h3);
      chk({7'h00, er}, 8'h00);
      chk(8'(nwr), 8'h03);
      xfer(1'b1, 1'b1, 7'h50, 8'h10, 4'h2);
      chk({7'h00, er}, 8'h00);
      chk(8'(nstart), 8'h03);
      chk(8'(got.size()), 8'h02);
      chk(got[0], 8'hA5);
      chk(got[1], 8'h3C);
      xfer(1'b1, 1'b0, 7'h50, 8'h00, 4'h1);
      chk(got[0], 8'h0F);
      $display("test write_read done");
   endtask
   task automatic t_row;
      wq = '{8'h11, 8'h22, 8'h33, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      xfer(1'b0, 1'b0, 7'h51, 8'h06, 4'h3);
      chk(8'(nwr), 8'h02);
      xfer(1'b1, 1'b1, 7'h51, 8'h06, 4'h3);
      chk(got[0], 8'h11);
      chk(got[1], 8'h22);
      chk(got[2], 8'h00);
      $display("test row done");
   endtask
   task automatic t_addrs;
      logic [6:0] devs [3];
      devs = '{7'h50, 7'h51, 7'h59};
      for (int i = 0; i < 3; i++) begin
         wq[0] = 8'h40 + 8'(i);
         xfer(1'b0, 1'b0, devs[i], 8'h28, 4'h1);
         xfer(1'b1, 1'b1, devs[i], 8'h28, 4'h0);
         chk(8'(got.size()), 8'h01);
         chk(got[0], 8'h40 + 8'(i));
      end
      $display("test addresses done");
   endtask
   task automatic t_bad;
      xfer(1'b0, 1'b0, 7'h33, 8'h00, 4'h1);
      chk({7'h00, er}, 8'h01);
      chk(8'(nwr), 8'h00);
      chk(8'(nstart), 8'h04);
      $display("test unmatched done");
   endtask
   initial begin
      rst = 1'b1;
      {cmd_valid, cmd_read, cmd_set_addr, wr_valid} = 4'h0;
      {cmd_dev, cmd_mem_addr, wr_data, cmd_len} = 27'h0;
      repeat (6) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      t_write_read();
      t_row();
      t_addrs();
      t_bad();
      report_and_stop();
   end
endmodule
